//--- sges_defines.svh
// register offsets, field positions, reset values and widths for the status event summary block
`ifndef SGES_DEFINES_SVH
`define SGES_DEFINES_SVH
`define SGES_COND_W 16
`define SGES_STD_W 8
`define SGES_SEL_STD_EVENT 4'h0
`define SGES_SEL_STD_ENABLE 4'h1
`define SGES_SEL_OPER_COND 4'h2
`define SGES_SEL_OPER_PTR 4'h3
`define SGES_SEL_OPER_NTR 4'h4
`define SGES_SEL_OPER_EVENT 4'h5
`define SGES_SEL_OPER_ENABLE 4'h6
`define SGES_SEL_QUES_COND 4'h7
`define SGES_SEL_QUES_PTR 4'h8
`define SGES_SEL_QUES_NTR 4'h9
`define SGES_SEL_QUES_EVENT 4'hA
`define SGES_SEL_QUES_ENABLE 4'hB
`define SGES_BIT_OPC 0
`define SGES_BIT_RQC 1
`define SGES_BIT_QYE 2
`define SGES_BIT_DDE 3
`define SGES_BIT_EXE 4
`define SGES_BIT_CME 5
`define SGES_BIT_URQ 6
`define SGES_BIT_PON 7
`define SGES_STB_ESB 5
`define SGES_STB_OSB 7
`define SGES_STB_QSB 3
`define SGES_STD_EVENT_RST 8'h80
`define SGES_ZERO16 16'h0000
`endif

//--- sges_pkg.sv
// types for the status event summary block
package sges_pkg;
    typedef struct packed {
        logic opc_done;
        logic query_err;
        logic dev_err;
        logic exec_err;
        logic cmd_err;
        logic local_key;
    } sges_std_evt_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] sel;
        logic [15:0] wdata;
    } sges_cmd_t;
    typedef enum logic [1:0] {SGES_IDLE, SGES_READ, SGES_CLEAR} sges_rd_state_t;
endpackage

//--- sges_trans_group.sv
// one status group: condition, transition filters, latched events, enable and summary
`timescale 1ns/100ps
`include "sges_defines.svh"
module sges_trans_group import sges_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [15:0] i_cond,
    input wire logic i_ptr_wr,
    input wire logic i_ntr_wr,
    input wire logic i_en_wr,
    input wire logic i_evt_clr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_ptr,
    output logic [15:0] o_ntr,
    output logic [15:0] o_event,
    output logic [15:0] o_enable,
    output logic o_summary
);
    logic [15:0] prev_q, prev_d, ptr_q, ptr_d, ntr_q, ntr_d, evt_q, evt_d, en_q, en_d;
    logic [15:0] hit;
    logic sum_q, sum_d;
    always_comb begin
        prev_d = i_cond;
        hit = (i_cond & ~prev_q & ptr_q) | (~i_cond & prev_q & ntr_q);
        ptr_d = i_ptr_wr ? i_wdata : ptr_q;
        ntr_d = i_ntr_wr ? i_wdata : ntr_q;
        en_d = i_en_wr ? i_wdata : en_q;
        evt_d = (i_evt_clr ? `SGES_ZERO16 : evt_q) | hit;
        sum_d = |(evt_d & en_d);
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_q <= `SGES_ZERO16;
            ptr_q <= `SGES_ZERO16;
            ntr_q <= `SGES_ZERO16;
            evt_q <= `SGES_ZERO16;
            en_q <= `SGES_ZERO16;
            sum_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            ptr_q <= ptr_d;
            ntr_q <= ntr_d;
            evt_q <= evt_d;
            en_q <= en_d;
            sum_q <= sum_d;
        end
    end
    assign o_ptr = ptr_q;
    assign o_ntr = ntr_q;
    assign o_event = evt_q;
    assign o_enable = en_q;
    assign o_summary = sum_q;

    chk_rise_sets_event: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_cond[0] && !prev_q[0] && ptr_q[0]) |=> evt_q[0])
        else $error("positive transition not latched");
    chk_fall_sets_event: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!i_cond[0] && prev_q[0] && ntr_q[0]) |=> evt_q[0])
        else $error("negative transition not latched");
    chk_event_stays_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (evt_q[1] && !i_evt_clr) |=> evt_q[1])
        else $error("event bit dropped without clear");
    chk_group_summary: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ##1 (o_summary == |($past(evt_d) & $past(en_d))))
        else $error("group summary mismatch");
endmodule // sges_trans_group

//--- sges_std_group.sv
// standard event group: direct event bits, enable mask and summary
`timescale 1ns/100ps
`include "sges_defines.svh"
module sges_std_group import sges_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire sges_std_evt_t i_evt,
    input wire logic i_en_wr,
    input wire logic i_evt_clr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_event,
    output logic [7:0] o_enable,
    output logic o_summary
);
    logic [7:0] evt_q, evt_d, en_q, en_d, set;
    logic sum_q, sum_d;
    always_comb begin
        set = 8'h00;
        set[`SGES_BIT_OPC] = i_evt.opc_done;
        set[`SGES_BIT_QYE] = i_evt.query_err;
        set[`SGES_BIT_DDE] = i_evt.dev_err;
        set[`SGES_BIT_EXE] = i_evt.exec_err;
        set[`SGES_BIT_CME] = i_evt.cmd_err;
        set[`SGES_BIT_URQ] = i_evt.local_key;
        evt_d = (i_evt_clr ? 8'h00 : evt_q) | set;
        evt_d[`SGES_BIT_RQC] = 1'b0;
        en_d = i_en_wr ? i_wdata : en_q;
        sum_d = |(evt_d & en_d);
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            evt_q <= `SGES_STD_EVENT_RST;
            en_q <= 8'h00;
            sum_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            en_q <= en_d;
            sum_q <= sum_d;
        end
    end
    assign o_event = evt_q;
    assign o_enable = en_q;
    assign o_summary = sum_q;

    chk_rqc_always_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        evt_q[`SGES_BIT_RQC] == 1'b0)
        else $error("request control bit set");
    chk_local_key_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_evt.local_key |=> evt_q[`SGES_BIT_URQ])
        else $error("local key event lost");
    chk_enable_readback: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_en_wr |=> (en_q == $past(i_wdata)))
        else $error("enable mask not as written");
endmodule // sges_std_group

//--- sges_status_top.sv
// status event summary top: three status groups, command port and status byte bits
`timescale 1ns/100ps
`include "sges_defines.svh"
module sges_status_top import sges_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [15:0] i_oper_cond,
    input wire logic [15:0] i_ques_cond,
    input wire sges_std_evt_t i_std_evt,
    input wire logic i_cls,
    input wire sges_cmd_t i_cmd,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_stb_esb,
    output logic o_stb_osb,
    output logic o_stb_qsb
);
    // condition inputs come from other domains
    logic [15:0] oper_s1_q, oper_s2_q, ques_s1_q, ques_s2_q;
    logic [5:0] std_s1_q, std_s2_q, std_s3_q;
    sges_std_evt_t std_pulse;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oper_s1_q <= `SGES_ZERO16;
            oper_s2_q <= `SGES_ZERO16;
            ques_s1_q <= `SGES_ZERO16;
            ques_s2_q <= `SGES_ZERO16;
            std_s1_q <= 6'h00;
            std_s2_q <= 6'h00;
            std_s3_q <= 6'h00;
        end else begin
            oper_s1_q <= i_oper_cond;
            oper_s2_q <= oper_s1_q;
            ques_s1_q <= i_ques_cond;
            ques_s2_q <= ques_s1_q;
            std_s1_q <= i_std_evt;
            std_s2_q <= std_s1_q;
            std_s3_q <= std_s2_q;
        end
    end
    // event requests are levels; their rising edge marks one event
    assign std_pulse = std_s2_q & ~std_s3_q;

    // decode of command port; reads of event registers are destructive
    logic oper_ptr_wr, oper_ntr_wr, oper_en_wr, ques_ptr_wr, ques_ntr_wr, ques_en_wr, std_en_wr;
    logic oper_clr, ques_clr, std_clr;
    always_comb begin
        oper_ptr_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_OPER_PTR;
        oper_ntr_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_OPER_NTR;
        oper_en_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_OPER_ENABLE;
        ques_ptr_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_QUES_PTR;
        ques_ntr_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_QUES_NTR;
        ques_en_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_QUES_ENABLE;
        std_en_wr = i_cmd.wr && i_cmd.sel == `SGES_SEL_STD_ENABLE;
        oper_clr = i_cls || (i_cmd.rd && i_cmd.sel == `SGES_SEL_OPER_EVENT);
        ques_clr = i_cls || (i_cmd.rd && i_cmd.sel == `SGES_SEL_QUES_EVENT);
        std_clr = i_cls || (i_cmd.rd && i_cmd.sel == `SGES_SEL_STD_EVENT);
    end

    logic [15:0] oper_ptr, oper_ntr, oper_evt, oper_en, ques_ptr, ques_ntr, ques_evt, ques_en;
    logic [7:0] std_evt, std_en;
    logic oper_sum, ques_sum, std_sum;

    sges_trans_group u_oper (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_cond(oper_s2_q),
        .i_ptr_wr(oper_ptr_wr),
        .i_ntr_wr(oper_ntr_wr),
        .i_en_wr(oper_en_wr),
        .i_evt_clr(oper_clr),
        .i_wdata(i_cmd.wdata),
        .o_ptr(oper_ptr),
        .o_ntr(oper_ntr),
        .o_event(oper_evt),
        .o_enable(oper_en),
        .o_summary(oper_sum)
    );
    sges_trans_group u_ques (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_cond(ques_s2_q),
        .i_ptr_wr(ques_ptr_wr),
        .i_ntr_wr(ques_ntr_wr),
        .i_en_wr(ques_en_wr),
        .i_evt_clr(ques_clr),
        .i_wdata(i_cmd.wdata),
        .o_ptr(ques_ptr),
        .o_ntr(ques_ntr),
        .o_event(ques_evt),
        .o_enable(ques_en),
        .o_summary(ques_sum)
    );
    sges_std_group u_std (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_evt(std_pulse),
        .i_en_wr(std_en_wr),
        .i_evt_clr(std_clr),
        .i_wdata(i_cmd.wdata[7:0]),
        .o_event(std_evt),
        .o_enable(std_en),
        .o_summary(std_sum)
    );

    // read mux: value taken before the clear lands
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    always_comb begin
        rvalid_d = i_cmd.rd;
        rdata_d = rdata_q;
        if (i_cmd.rd) begin
            case (i_cmd.sel)
                `SGES_SEL_STD_EVENT: rdata_d = {8'h00, std_evt};
                `SGES_SEL_STD_ENABLE: rdata_d = {8'h00, std_en};
                `SGES_SEL_OPER_COND: rdata_d = oper_s2_q;
                `SGES_SEL_OPER_PTR: rdata_d = oper_ptr;
                `SGES_SEL_OPER_NTR: rdata_d = oper_ntr;
                `SGES_SEL_OPER_EVENT: rdata_d = oper_evt;
                `SGES_SEL_OPER_ENABLE: rdata_d = oper_en;
                `SGES_SEL_QUES_COND: rdata_d = ques_s2_q;
                `SGES_SEL_QUES_PTR: rdata_d = ques_ptr;
                `SGES_SEL_QUES_NTR: rdata_d = ques_ntr;
                `SGES_SEL_QUES_EVENT: rdata_d = ques_evt;
                `SGES_SEL_QUES_ENABLE: rdata_d = ques_en;
                default: rdata_d = `SGES_ZERO16;
            endcase
        end
    end

    logic esb_q, osb_q, qsb_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= `SGES_ZERO16;
            rvalid_q <= 1'b0;
            esb_q <= 1'b0;
            osb_q <= 1'b0;
            qsb_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            esb_q <= std_sum;
            osb_q <= oper_sum;
            qsb_q <= ques_sum;
        end
    end
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_stb_esb = esb_q;
    assign o_stb_osb = osb_q;
    assign o_stb_qsb = qsb_q;

    chk_cond_live_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_cmd.rd && i_cmd.sel == `SGES_SEL_OPER_COND) |=> (o_rdata == $past(oper_s2_q)))
        else $error("condition read not live");
    chk_esb_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ##1 (o_stb_esb == $past(std_sum)))
        else $error("status bit five not from standard group");
    chk_osb_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ##1 (o_stb_osb == $past(oper_sum)))
        else $error("status bit seven not from operation group");
    chk_event_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_cmd.rd && i_cmd.sel == `SGES_SEL_STD_EVENT && !std_pulse.opc_done)
        |=> (o_rdata[7:0] == $past(std_evt)) && !std_evt[`SGES_BIT_PON])
        else $error("standard event read wrong or not cleared");
endmodule // sges_status_top

//--- sges_src_model.sv
// condition sources and event pulser standing in front of the status block
`timescale 1ns/100ps
module sges_src_model import sges_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [15:0] i_oper_lvl,
    input wire logic [15:0] i_ques_lvl,
    input wire logic [5:0] i_evt_req,
    output logic [15:0] o_oper_cond,
    output logic [15:0] o_ques_cond,
    output sges_std_evt_t o_std_evt
);
    logic [1:0] hold_q;
    logic [5:0] evt_q;
    // live levels, any change is a potential transition
    assign o_oper_cond = i_oper_lvl;
    assign o_ques_cond = i_ques_lvl;
    // each request makes one 0->1 event edge, held long enough to sync
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            evt_q <= 6'h00;
            hold_q <= 2'h0;
        end else if (i_evt_req != 6'h00) begin
            evt_q <= i_evt_req;
            hold_q <= 2'h3;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else begin
            evt_q <= 6'h00;
        end
    end
    assign o_std_evt = sges_std_evt_t'(evt_q);
endmodule // sges_src_model

//--- tb_top.sv
// self-checking bench for the status event summary block
`timescale 1ns/100ps
`include "sges_defines.svh"
module tb_top import sges_pkg::*; ;
    logic i_clk, i_rst_b, i_cls, o_rvalid, o_stb_esb, o_stb_osb, o_stb_qsb;
    logic [15:0] oper_lvl, ques_lvl, oper_cond, ques_cond, o_rdata;
    logic [5:0] evt_req;
    sges_std_evt_t std_evt;
    sges_cmd_t cmd;
    int mismatches, checks_done, seed;
    logic [15:0] ptr, ntr, en, old_v, new_v, ev;
    logic [3:0] base;
    sges_src_model i_src (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_oper_lvl(oper_lvl), .i_ques_lvl(ques_lvl),
        .i_evt_req(evt_req), .o_oper_cond(oper_cond), .o_ques_cond(ques_cond), .o_std_evt(std_evt));
    sges_status_top i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_oper_cond(oper_cond), .i_ques_cond(ques_cond),
        .i_std_evt(std_evt), .i_cls(i_cls), .i_cmd(cmd), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_stb_esb(o_stb_esb), .o_stb_osb(o_stb_osb), .o_stb_qsb(o_stb_qsb));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(logic [3:0] s, logic [15:0] d);
        cmd <= '{1'b1, 1'b0, s, d};
        @(posedge i_clk);
        cmd <= '0;
    endtask
    // read one register, wait bounded for the answer, then compare
    task automatic rd(logic [3:0] s, logic [15:0] e);
        int n;
        cmd <= '{1'b0, 1'b1, s, 16'h0000};
        @(posedge i_clk);
        cmd <= '0;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_rvalid !== 1'b1 && n < 4);
        if (o_rvalid !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        chk(o_rdata, e);
        @(posedge i_clk);
    endtask
    function automatic logic [7:0] std_bit(int i);
        return (i == 5) ? 8'h01 : 8'h01 << (6 - i);
    endfunction
    function automatic logic [15:0] trans(logic [15:0] p, logic [15:0] q, logic [15:0] a, logic [15:0] b);
        return (p & ~a & b) | (q & a & ~b);
    endfunction
    initial begin
        seed = 6479;
        mismatches = 0;
        checks_done = 0;
        i_rst_b = 1'b0;
        i_cls = 1'b0;
        cmd = '0;
        oper_lvl = 16'h0000;
        ques_lvl = 16'h0000;
        evt_req = 6'h00;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        rd(`SGES_SEL_STD_EVENT, 16'h0080);
        rd(`SGES_SEL_STD_EVENT, 16'h0000);
        rd(`SGES_SEL_OPER_PTR, 16'h0000);
        rd(4'hF, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            en = {8'h00, 8'($random(seed))};
            wr(`SGES_SEL_STD_ENABLE, en);
            rd(`SGES_SEL_STD_ENABLE, en);
            evt_req <= 6'h01 << i;
            @(posedge i_clk);
            evt_req <= 6'h00;
            repeat (10) @(posedge i_clk);
            @(negedge i_clk);
            chk(o_stb_esb, {15'h0000, |(en[7:0] & std_bit(i))});
            @(posedge i_clk);
            rd(`SGES_SEL_STD_EVENT, {8'h00, std_bit(i)});
        end
        for (int g = 0; g < 2; g++) begin
            base = g ? `SGES_SEL_QUES_COND : `SGES_SEL_OPER_COND;
            for (int k = 0; k < 4; k++) begin
                {ptr, ntr, en, old_v, new_v} = {$random(seed), $random(seed), $random(seed)};
                if (k == 0) {ptr, ntr, old_v, new_v} = {16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF};
                wr(base + 4'h1, 16'h0000);
                wr(base + 4'h2, 16'h0000);
                if (g) ques_lvl <= old_v;
                else oper_lvl <= old_v;
                repeat (8) @(posedge i_clk);
                i_cls <= 1'b1;
                @(posedge i_clk);
                i_cls <= 1'b0;
                repeat (2) @(posedge i_clk);
                rd(base + 4'h3, 16'h0000);
                wr(base + 4'h1, ptr);
                wr(base + 4'h2, ntr);
                wr(base + 4'h4, en);
                rd(base + 4'h1, ptr);
                if (g) ques_lvl <= new_v;
                else oper_lvl <= new_v;
                repeat (10) @(posedge i_clk);
                ev = trans(ptr, ntr, old_v, new_v);
                @(negedge i_clk);
                chk(g ? o_stb_qsb : o_stb_osb, {15'h0000, |(ev & en)});
                @(posedge i_clk);
                rd(base, new_v);
                rd(base + 4'h3, ev);
                rd(base + 4'h3, 16'h0000);
            end
        end
        give_verdict();
    end
endmodule // tb_top
